// ===== baud_pkg.sv
// shared constants and carrier types for the serial baud rate generator
package baud_pkg;

  // ==========================================================
  // register map (word addresses on the avalon slave)
  // ==========================================================
  localparam logic [3:0] OFF_BAUD_HIGH = 4'h0;
  localparam logic [3:0] OFF_BAUD_LOW = 4'h1;
  localparam logic [3:0] OFF_CONTROL_TWO = 4'h2;
  localparam logic [3:0] OFF_SYS_OPTIONS = 4'h3;
  localparam logic [3:0] OFF_IRQ_STATUS = 4'h4;
  localparam logic [3:0] OFF_IRQ_MASK = 4'h5;
  localparam logic [3:0] OFF_LINE_EVENTS = 4'h6;

  // ==========================================================
  // field positions and reset values
  // ==========================================================
  localparam int BIT_LBK_IE = 7;
  localparam int BIT_RXE_IE = 6;
  localparam int BIT_TE = 3;
  localparam int BIT_RE = 2;
  localparam int BIT_BRK13 = 1;
  localparam int BIT_SEND_BRK = 0;
  localparam int BIT_PS = 0;
  localparam int DIV_W = 13;
  localparam logic [7:0] RST_BAUD_HIGH = 8'h00;
  localparam logic [7:0] RST_BAUD_LOW = 8'h04;
  localparam logic [7:0] RST_ZERO = 8'h00;

  // ==========================================================
  // timing figures
  // ==========================================================
  localparam int TICKS_PER_BIT = 16;
  localparam int BRK_TX_BITS = 13;
  localparam int BRK_TX_BITS_SHORT = 10;
  localparam int BRK_DET_BITS = 11;

  // status layout: [0] line break, [1] rx edge
  typedef struct packed {
    logic rx_edge;
    logic line_break;
  } irq_bits_t;

  typedef struct packed {
    logic [3:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
  } av_req_t;

endpackage : baud_pkg

// ===== baud_tick_gen.sv
// modulo divisor counter producing the sixteen-times oversampling tick
`timescale 1ns/10ps
module baud_tick_gen
  import baud_pkg::*;
#(
  parameter int W = DIV_W
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic enable,
  input wire logic [W-1:0] divisor,
  output logic tick
);

  initial begin
    if (W < 1 || W > 16) $error("divisor width out of range");
  end

  logic [W-1:0] count_r;

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      count_r <= '0;
      tick <= 1'b0;
    end else if (!enable || divisor == '0) begin
      count_r <= '0;
      tick <= 1'b0;
    end else if (count_r >= divisor - W'(1)) begin
      count_r <= '0;
      tick <= 1'b1;
    end else begin
      count_r <= count_r + W'(1);
      tick <= 1'b0;
    end
  end

endmodule : baud_tick_gen

// ===== serial_baud_rate_generator.sv
// baud divisor registers, break handling, interrupts and pin routing
//
// Our own choices: the address map and the Avalon-MM interface to the registers.
`timescale 1ns/10ps

// Overview of operation
// - position bit 0 routes port two to port f pins, 1 to port e
// - high half held aside, moved to working divisor on low write
// - low half resets non-zero; generator off until rx or tx enabled
// - divisor of zero stops the baud generator
// - baud rate is bus clock over sixteen times divisor
// - high register bits 4:0 hold divisor 12:8, low holds 7:0
// - high bit 7 lets line break flag raise the interrupt
// - high bit 6 lets rx edge flag raise the interrupt
// - optional 13-bit break send, 11-bit break detect
module serial_baud_rate_generator
  import baud_pkg::*;
(
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic irq,
  output logic baud_tick,
  output logic port2_transmit_pin,
  input wire logic port2_receive_pin,
  input wire logic port2_tx_data,
  output logic port2_rx_data,
  output logic port_f_pin0,
  output logic port_e_pin6,
  input wire logic port_f_pin1,
  input wire logic port_e_pin7
);

  // ==========================================================
  // bus request capture
  // ==========================================================
  av_req_t req;
  logic ack_r;
  logic do_wr;
  logic do_rd;

  assign req = '{address: avs_address, read: avs_read, write: avs_write,
                 writedata: avs_writedata};
  // write lands at the edge where the master sees waitrequest low
  assign do_wr = req.write && ack_r;
  assign do_rd = req.read && !ack_r;

  // one wait cycle, then acknowledge
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= (req.read || req.write) && !ack_r;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= !((req.read || req.write) && !ack_r);
    end
  end

  // ==========================================================
  // divisor registers
  // ==========================================================
  logic [7:0] high_hold_r;
  logic [7:0] high_work_r;
  logic [7:0] low_r;
  logic [DIV_W-1:0] baud_divisor_value;
  logic gen_armed_r;

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      high_hold_r <= RST_BAUD_HIGH;
    end else if (do_wr && req.address == OFF_BAUD_HIGH) begin
      high_hold_r <= req.writedata[7:0];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      high_work_r <= RST_BAUD_HIGH;
      low_r <= RST_BAUD_LOW;
    end else if (do_wr && req.address == OFF_BAUD_LOW) begin
      high_work_r <= high_hold_r;
      low_r <= req.writedata[7:0];
    end
  end

  assign baud_divisor_value = {high_work_r[4:0], low_r};

  // ==========================================================
  // control two, system options, mask
  // ==========================================================
  logic [7:0] control_two_r;
  logic [7:0] sys_opts_r;
  logic [1:0] mask_r;

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      control_two_r <= RST_ZERO;
    end else if (do_wr && req.address == OFF_CONTROL_TWO) begin
      control_two_r <= {4'h0, req.writedata[3:0]};
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      gen_armed_r <= 1'b0;
    end else if (do_wr && req.address == OFF_CONTROL_TWO &&
                 (req.writedata[BIT_TE] || req.writedata[BIT_RE])) begin
      gen_armed_r <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      sys_opts_r <= RST_ZERO;
    end else if (do_wr && req.address == OFF_SYS_OPTIONS) begin
      sys_opts_r <= {7'h00, req.writedata[BIT_PS]};
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      mask_r <= 2'h3;
    end else if (do_wr && req.address == OFF_IRQ_MASK) begin
      mask_r <= req.writedata[1:0];
    end
  end

  // ==========================================================
  // tick generator
  // ==========================================================
  logic tick;
  logic gen_enable;

  assign gen_enable = gen_armed_r && (control_two_r[BIT_TE] || control_two_r[BIT_RE]);

  baud_tick_gen #(
    .W(DIV_W)
  ) u_tick (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .enable(gen_enable),
    .divisor(baud_divisor_value),
    .tick(tick)
  );

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      baud_tick <= 1'b0;
    end else begin
      baud_tick <= tick;
    end
  end

  // ==========================================================
  // pin routing and receive synchroniser
  // ==========================================================
  logic ps;
  logic rx_raw;
  logic rx_s1_r;
  logic rx_s2_r;
  logic rx_s3_r;

  assign ps = sys_opts_r[BIT_PS];
  assign rx_raw = ps ? port_e_pin7 : port_f_pin1;

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      rx_s1_r <= 1'b1;
      rx_s2_r <= 1'b1;
      rx_s3_r <= 1'b1;
    end else begin
      rx_s1_r <= rx_raw;
      rx_s2_r <= rx_s1_r;
      rx_s3_r <= rx_s2_r;
    end
  end

  logic brk_tx_active_r;

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      port_f_pin0 <= 1'b1;
      port_e_pin6 <= 1'b1;
      port2_transmit_pin <= 1'b1;
      port2_rx_data <= 1'b1;
    end else begin
      port2_transmit_pin <= port2_tx_data && !brk_tx_active_r;
      port_f_pin0 <= ps ? 1'b1 : (port2_tx_data && !brk_tx_active_r);
      port_e_pin6 <= ps ? (port2_tx_data && !brk_tx_active_r) : 1'b1;
      port2_rx_data <= rx_s2_r;
    end
  end

  // ==========================================================
  // break send and detect
  // ==========================================================
  localparam int BRK_CNT_W = 8;
  localparam logic [BRK_CNT_W-1:0] BRK_TX_LONG = BRK_CNT_W'(BRK_TX_BITS * TICKS_PER_BIT);
  localparam logic [BRK_CNT_W-1:0] BRK_TX_SHORT =
    BRK_CNT_W'(BRK_TX_BITS_SHORT * TICKS_PER_BIT);
  localparam logic [BRK_CNT_W-1:0] BRK_DET = BRK_CNT_W'(BRK_DET_BITS * TICKS_PER_BIT);

  logic [BRK_CNT_W-1:0] brk_tx_cnt_r;
  logic [BRK_CNT_W-1:0] brk_rx_cnt_r;
  logic brk_seen_r;
  logic break_event;
  logic edge_event;

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      brk_tx_cnt_r <= '0;
      brk_tx_active_r <= 1'b0;
    end else if (!brk_tx_active_r && control_two_r[BIT_SEND_BRK] && gen_enable) begin
      brk_tx_active_r <= 1'b1;
      brk_tx_cnt_r <= control_two_r[BIT_BRK13] ? BRK_TX_LONG : BRK_TX_SHORT;
    end else if (brk_tx_active_r && tick) begin
      if (brk_tx_cnt_r == BRK_CNT_W'(1)) begin
        brk_tx_active_r <= 1'b0;
      end
      brk_tx_cnt_r <= brk_tx_cnt_r - BRK_CNT_W'(1);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      brk_rx_cnt_r <= '0;
      brk_seen_r <= 1'b0;
    end else if (rx_s2_r) begin
      brk_rx_cnt_r <= '0;
      brk_seen_r <= 1'b0;
    end else if (tick && !brk_seen_r) begin
      brk_rx_cnt_r <= brk_rx_cnt_r + BRK_CNT_W'(1);
      if (brk_rx_cnt_r == BRK_DET - BRK_CNT_W'(1)) begin
        brk_seen_r <= 1'b1;
      end
    end
  end

  assign break_event = tick && !brk_seen_r && !rx_s2_r &&
                       brk_rx_cnt_r == BRK_DET - BRK_CNT_W'(1);
  assign edge_event = rx_s3_r && !rx_s2_r;

  // ==========================================================
  // sticky flags and interrupt
  // ==========================================================
  irq_bits_t status_r;
  logic rd_status;

  assign rd_status = do_rd && req.address == OFF_IRQ_STATUS;

  // set wins over read clear
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      status_r <= '0;
    end else begin
      status_r.line_break <= break_event || (status_r.line_break && !rd_status);
      status_r.rx_edge <= edge_event || (status_r.rx_edge && !rd_status);
    end
  end

  // enables in high bits 7 and 6
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      irq <= 1'b0;
    end else begin
      irq <= (status_r.line_break && high_hold_r[BIT_LBK_IE] && mask_r[0]) ||
             (status_r.rx_edge && high_hold_r[BIT_RXE_IE] && mask_r[1]);
    end
  end

  // ==========================================================
  // read data
  // ==========================================================
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      avs_readdata <= '0;
    end else if (do_rd) begin
      unique case (req.address)
        OFF_BAUD_HIGH: avs_readdata <= {24'h0, high_hold_r[7:6], 1'b0, high_hold_r[4:0]};
        OFF_BAUD_LOW: avs_readdata <= {24'h0, low_r};
        OFF_CONTROL_TWO: avs_readdata <= {24'h0, control_two_r};
        OFF_SYS_OPTIONS: avs_readdata <= {24'h0, sys_opts_r};
        OFF_IRQ_STATUS: avs_readdata <= {30'h0, status_r};
        OFF_IRQ_MASK: avs_readdata <= {30'h0, mask_r};
        OFF_LINE_EVENTS: avs_readdata <= {29'h0, brk_tx_active_r, brk_seen_r, rx_s2_r};
        default: avs_readdata <= '0;
      endcase
    end
  end

endmodule : serial_baud_rate_generator

// ===== baud_chk.sv
// assertion checker for the baud rate generator ports
`timescale 1ns/10ps
module baud_chk
  import baud_pkg::*;
(
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic irq,
  input wire logic baud_tick,
  input wire logic port_f_pin0,
  input wire logic port_e_pin6,
  input wire logic port_f_pin1,
  input wire logic port2_rx_data
);
  // ==========
  // shadow state
  // ==========
  logic acc;
  logic ps_r;
  logic seen_r;
  logic [7:0] hi_r;
  logic [12:0] div_r;
  logic [13:0] gap_r;
  assign acc = avs_write && !avs_waitrequest;
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      hi_r <= RST_BAUD_HIGH;
      div_r <= {5'h00, RST_BAUD_LOW};
      ps_r <= 1'h0;
    end else begin
      if (acc && avs_address == OFF_BAUD_HIGH) hi_r <= avs_writedata[7:0];
      if (acc && avs_address == OFF_BAUD_LOW) div_r <= {hi_r[4:0], avs_writedata[7:0]};
      if (acc && avs_address == OFF_SYS_OPTIONS) ps_r <= avs_writedata[BIT_PS];
    end
  end
  // cycles since last tick; any write restarts the watch
  always_ff @(posedge clk_sys) begin
    seen_r <= nrst && !acc && (seen_r || baud_tick);
    gap_r <= baud_tick ? 14'h0001 : gap_r + 14'h0001;
  end
  // ==========
  // properties
  // ==========
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  sequence s_req; (avs_read || avs_write) && avs_waitrequest; endsequence
  sequence s_rd; avs_read && !avs_waitrequest; endsequence
  sequence s_clr; s_rd ##0 avs_address == OFF_IRQ_STATUS; endsequence
  property p_ans; s_req |=> !avs_waitrequest; endproperty
  property p_one; !avs_waitrequest |=> avs_waitrequest; endproperty
  property p_unm; s_rd ##0 avs_address > OFF_LINE_EVENTS |-> avs_readdata == 32'h00000000;
  endproperty
  property p_rdbk;
    s_rd ##0 avs_address == OFF_BAUD_HIGH |-> avs_readdata[7:0] == (hi_r & 8'hDF);
  endproperty
  property p_period; baud_tick && seen_r |-> gap_r == {1'h0, div_r}; endproperty
  property p_zero; (div_r == 13'h0000)[*3] |-> !baud_tick; endproperty
  property p_pin; ps_r == $past(ps_r) |-> (ps_r ? port_f_pin0 : port_e_pin6); endproperty
  property p_rx; !ps_r && !$past(ps_r, 4) |-> port2_rx_data == $past(port_f_pin1, 3);
  endproperty
  property p_noen; hi_r[7:6] == 2'h0 && $past(hi_r[7:6]) == 2'h0 |-> !irq; endproperty
  property p_clr; s_clr |-> ##[1:2] !irq; endproperty
  property p_rst; $rose(nrst) |-> avs_waitrequest && !irq && !baud_tick && port_f_pin0;
  endproperty
  a_ans: assert property (p_ans) else $error("no answer");
  a_one: assert property (p_one) else $error("wait low too long");
  a_unm: assert property (p_unm) else $error("unmapped read nonzero");
  a_rdbk: assert property (p_rdbk) else $error("high readback");
  a_period: assert property (p_period) else $error("tick period");
  a_zero: assert property (p_zero) else $error("tick at zero");
  a_pin: assert property (p_pin) else $error("idle pin");
  a_rx: assert property (p_rx) else $error("rx routing");
  a_noen: assert property (p_noen) else $error("irq disabled");
  a_clr: assert property (p_clr) else $error("irq stuck");
  a_rst: assert property (p_rst) else $error("reset outputs");
endmodule : baud_chk

bind serial_baud_rate_generator baud_chk u_chk (.clk_sys, .nrst, .avs_address, .avs_read,
  .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .irq, .baud_tick,
  .port_f_pin0, .port_e_pin6, .port_f_pin1, .port2_rx_data);

// ===== remote_node.sv
// far serial node driving the receive pins
`timescale 1ns/10ps
module remote_node (
  input wire logic clk_sys,
  input wire logic on_e,
  input wire logic hold_low,
  output logic rx_f,
  output logic rx_e
);
  // ==========
  // line drive
  // ==========
  // unused pin rests at its pull-up level
  initial begin
    rx_f = 1'h1;
    rx_e = 1'h1;
  end
  always @(posedge clk_sys) begin
    rx_f <= !(hold_low && !on_e);
    rx_e <= !(hold_low && on_e);
  end
endmodule : remote_node

// ===== tb.sv
// self-checking bench for the baud rate generator
`timescale 1ns/10ps
module tb
  import baud_pkg::*;
;
  logic clk_sys = 1'h0;
  logic nrst = 1'h0;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'h0;
  logic avs_write = 1'h0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest, irq, baud_tick, port2_transmit_pin, port2_rx_data;
  logic port_f_pin0, port_e_pin6, port_f_pin1, port_e_pin7;
  logic port2_tx_data = 1'h1;
  logic hold_low = 1'h0;
  logic on_e = 1'h0;
  int errors = 0;
  int checks = 0;
  always #5 clk_sys = ~clk_sys;
  serial_baud_rate_generator dut (.clk_sys, .nrst, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_readdata, .avs_waitrequest, .irq, .baud_tick, .port2_transmit_pin,
    .port2_receive_pin(1'h1), .port2_tx_data, .port2_rx_data, .port_f_pin0, .port_e_pin6,
    .port_f_pin1, .port_e_pin7);
  remote_node u_far (.clk_sys, .on_e, .hold_low, .rx_f(port_f_pin1), .rx_e(port_e_pin7));
  // ==========
  // helpers
  // ==========
  task print_verdict;
    $display("errors %0d checks %0d", errors, checks);
    if (errors == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : print_verdict
  task chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      errors++;
      $display("BAD %0t got %h want %h", $time, g, e);
    end
  endtask : chk
  task bus(input logic w, input logic [3:0] a, input logic [7:0] d, input logic [7:0] e);
    int n;
    @(posedge clk_sys);
    avs_address <= a;
    avs_writedata <= {24'h000000, d};
    avs_write <= w;
    avs_read <= !w;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (avs_waitrequest !== 1'h0 && n < 50);
    if (!w) chk(avs_readdata, {24'h000000, e});
    avs_write <= 1'h0;
    avs_read <= 1'h0;
    if (n >= 50) begin
      errors++;
      print_verdict();
    end
  endtask : bus
  task wr(input logic [3:0] a, input logic [7:0] d);
    bus(1'h1, a, d, 8'h00);
  endtask : wr
  task rd(input logic [3:0] a, input logic [7:0] e);
    bus(1'h0, a, 8'h00, e);
  endtask : rd
  task gap(input int e);
    int n;
    int g;
    // skip ticks left over from the previous divisor
    repeat (2) begin
      n = 0;
      do begin
        @(posedge clk_sys);
        n++;
      end while (baud_tick !== 1'h1 && n < 600);
      if (n >= 600) errors++;
    end
    g = 0;
    do begin
      @(posedge clk_sys);
      g++;
    end while (baud_tick !== 1'h1 && g < 600);
    chk(g, e);
  endtask : gap
  task quiet(input int c);
    int k;
    k = 0;
    repeat (3) @(posedge clk_sys);
    repeat (c) begin
      @(posedge clk_sys);
      if (baud_tick !== 1'h0) k++;
    end
    chk(k, 0);
  endtask : quiet
  task pulse(input int c);
    hold_low <= 1'h1;
    repeat (c) @(posedge clk_sys);
    hold_low <= 1'h0;
    repeat (8) @(posedge clk_sys);
  endtask : pulse
  // ==========
  // scenarios
  // ==========
  task t_reset;
    rd(OFF_BAUD_LOW, 8'h04);
    rd(OFF_BAUD_HIGH, 8'h00);
    rd(OFF_IRQ_MASK, 8'h03);
    quiet(60);
    wr(4'hF, 8'hFF);
    rd(4'hF, 8'h00);
  endtask : t_reset
  task t_div;
    wr(OFF_CONTROL_TWO, 8'h08);
    wr(OFF_BAUD_HIGH, 8'h00);
    wr(OFF_BAUD_LOW, 8'h03);
    gap(3);
    wr(OFF_BAUD_HIGH, 8'h01);
    gap(3);
    rd(OFF_BAUD_HIGH, 8'h01);
    wr(OFF_BAUD_LOW, 8'h00);
    gap(256);
    wr(OFF_BAUD_HIGH, 8'h00);
    wr(OFF_BAUD_LOW, 8'h00);
    quiet(40);
    wr(OFF_BAUD_LOW, 8'h01);
    gap(1);
  endtask : t_div
  task t_pins;
    for (int s = 0; s < 2; s++) begin
      wr(OFF_SYS_OPTIONS, 8'(s));
      on_e <= s[0];
      port2_tx_data <= 1'h0;
      hold_low <= 1'h1;
      repeat (8) @(posedge clk_sys);
      chk({port_f_pin0, port_e_pin6}, s ? 2'h2 : 2'h1);
      chk(port2_rx_data, 1'h0);
      chk(port2_transmit_pin, 1'h0);
      port2_tx_data <= 1'h1;
      hold_low <= 1'h0;
      repeat (8) @(posedge clk_sys);
    end
    wr(OFF_SYS_OPTIONS, 8'h00);
    on_e <= 1'h0;
    wr(OFF_CONTROL_TWO, 8'h0B);
    repeat (4) @(posedge clk_sys);
    chk(port2_transmit_pin, 1'h0);
    rd(OFF_LINE_EVENTS, 8'h05);
    wr(OFF_CONTROL_TWO, 8'h08);
    repeat (220) @(posedge clk_sys);
    chk(port2_transmit_pin, 1'h1);
  endtask : t_pins
  task t_irq;
    rd(OFF_IRQ_STATUS, 8'h02);
    wr(OFF_BAUD_HIGH, 8'h40);
    pulse(4);
    chk(irq, 1'h1);
    rd(OFF_IRQ_STATUS, 8'h02);
    repeat (3) @(posedge clk_sys);
    chk(irq, 1'h0);
    wr(OFF_IRQ_MASK, 8'h00);
    pulse(4);
    chk(irq, 1'h0);
    wr(OFF_IRQ_MASK, 8'h03);
    repeat (3) @(posedge clk_sys);
    chk(irq, 1'h1);
    rd(OFF_IRQ_STATUS, 8'h02);
    wr(OFF_BAUD_HIGH, 8'h80);
    pulse(400);
    chk(irq, 1'h1);
    rd(OFF_IRQ_STATUS, 8'h03);
    repeat (3) @(posedge clk_sys);
    chk(irq, 1'h0);
  endtask : t_irq
  initial begin
    repeat (8) @(posedge clk_sys);
    nrst <= 1'h1;
    t_reset();
    t_div();
    t_pins();
    t_irq();
    print_verdict();
  end
endmodule : tb
